// ### hdl/csc_pkg.sv
// constants, types and register map of the capacitive scan controller
package csc_pkg;

  // register addresses, eight-bit serial address field
  localparam logic [7:0] ADDR_CAL        = 8'h01;
  localparam logic [7:0] ADDR_RAMP_START = 8'h02;
  localparam logic [7:0] ADDR_XFER_START = 8'h03;
  localparam logic [7:0] ADDR_SCAN_STATE = 8'h04;
  localparam logic [7:0] ADDR_XFER_STATE = 8'h05;
  localparam logic [7:0] ADDR_WAIT_END   = 8'h09;
  localparam logic [7:0] ADDR_STIM_GAIN  = 8'h0a;
  localparam logic [7:0] ADDR_PHASE_COEF = 8'h10;
  localparam logic [7:0] ADDR_GAIN_COEF  = 8'h11;
  localparam logic [7:0] ADDR_RESET_LEN  = 8'h1f;
  localparam logic [7:0] ADDR_TEST_MODE  = 8'h20;

  // serial frame shape
  localparam int unsigned SPI_ADDR_BITS  = 8;
  localparam int unsigned SPI_FRAME_BITS = 24;

  // test mode register fields
  localparam int unsigned TM_ENABLE_BIT = 0;
  localparam int unsigned TM_STEP_EN_BIT = 1;
  localparam int unsigned TM_STEP_BIT = 2;

  // reset values
  localparam logic [3:0]  RST_RESET_LEN  = 4'h7;
  localparam logic [3:0]  RST_UPPER_REF  = 4'hf;
  localparam logic [3:0]  RST_LOWER_REF  = 4'h1;
  localparam logic [5:0]  RST_STIM_FREQ  = 6'h07;
  localparam logic [5:0]  STIM_FREQ_ILL  = 6'h00;
  localparam logic [5:0]  STIM_FREQ_MIN  = 6'h01;
  localparam logic [9:0]  RST_RAMP_START = 10'h000;
  localparam logic [9:0]  RST_XFER_START = 10'h000;
  localparam logic [15:0] RST_WAIT_END   = 16'h0280;
  localparam logic [3:0]  RST_STIM_GAIN  = 4'h3;
  localparam logic [9:0]  RST_PHASE_COEF = 10'h080;
  localparam logic [9:0]  RST_GAIN_COEF  = 10'h000;

  // counter and array limits
  localparam logic [9:0]  COUNT_TOP      = 10'h3ff;
  localparam logic [9:0]  ROWS_PRESENT   = 10'h320;

  // calibration register layout
  typedef struct packed {
    logic [3:0] upper_ref;
    logic [3:0] lower_ref;
    logic [1:0] unused;
    logic [5:0] stim_freq;
  } csc_cal_t;

  // one completed serial frame
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [15:0] data;
  } csc_spi_req_t;

  typedef enum logic [5:0] {
    SCAN_IDLE    = 6'b00_0001,
    SCAN_CLEAR   = 6'b00_0010,
    SCAN_SETTLE  = 6'b00_0100,
    SCAN_READ    = 6'b00_1000,
    SCAN_WAITRDY = 6'b01_0000,
    SCAN_NEXT    = 6'b10_0000
  } csc_scan_state_t;

  typedef enum logic [2:0] {
    XFER_IDLE  = 3'b001,
    XFER_SYNC  = 3'b010,
    XFER_SHIFT = 3'b100
  } csc_xfer_state_t;

endpackage

// ### hdl/csc_spi_slave.sv
// serial register slave, sampled on the core clock
`timescale 1ns/1ps
module csc_spi_slave
  import csc_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         spi_sclk,
  input  wire logic         spi_sel_n,
  input  wire logic         spi_mosi,
  input  wire logic [15:0]  rd_data,
  output logic [7:0]        rd_addr,
  output csc_spi_req_t      wr_req,
  output logic              spi_miso,
  output logic              spi_miso_oe
);

  logic [2:0]  sclk_s;
  logic [1:0]  sel_s;
  logic [1:0]  mosi_s;
  logic [4:0]  bit_cnt;
  logic [14:0] shift;
  logic        rise;

  // two flops before any use; third sclk stage only feeds the edge detect
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sclk_s <= 3'b000;
      sel_s  <= 2'b11;
      mosi_s <= 2'b00;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      sel_s  <= {sel_s[0], spi_sel_n};
      mosi_s <= {mosi_s[0], spi_mosi};
    end

  assign rise = sclk_s[1] & ~sclk_s[2];

  // input sampled on rising sclk, msb first
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      bit_cnt <= 5'h00;
      shift   <= 15'h0000;
      rd_addr <= 8'h00;
      wr_req  <= '0;
    end
    else
    begin
      wr_req.wr <= 1'b0;
      if (sel_s[1])
        bit_cnt <= 5'h00;
      else if (rise && bit_cnt < 5'(SPI_FRAME_BITS))
      begin
        shift   <= {shift[13:0], mosi_s[1]};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'(SPI_ADDR_BITS - 1))
          rd_addr <= {shift[6:0], mosi_s[1]};
        if (bit_cnt == 5'(SPI_FRAME_BITS - 1))
          wr_req <= {1'b1, rd_addr, shift[14:0], mosi_s[1]};
      end
    end

  // reply bits change on rising sclk, msb first
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      spi_miso <= 1'b0;
    else if (!sel_s[1] && rise && bit_cnt >= 5'(SPI_ADDR_BITS)
             && bit_cnt < 5'(SPI_FRAME_BITS))
      spi_miso <= rd_data[4'(5'(SPI_FRAME_BITS - 1) - bit_cnt)];

  assign spi_miso_oe = ~sel_s[1];

endmodule

// ### hdl/csc_counter.sv
// ten-bit start-to-top counter with ready, shift and single step
`timescale 1ns/1ps
module csc_counter
  import csc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        start,
  input  wire logic [9:0]  start_value,
  input  wire logic        step_mode,
  input  wire logic        step,
  output logic [9:0]       count,
  output logic             running,
  output logic             ready
);

  // one start pulse runs from start value up to the top
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      count   <= 10'h000;
      running <= 1'b0;
      ready   <= 1'b1;
    end
    else if (clear)
    begin
      count   <= 10'h000;
      running <= 1'b0;
      ready   <= 1'b1;
    end
    else if (start)
    begin
      count   <= start_value;
      running <= 1'b1;
      ready   <= 1'b0;
    end
    else if (running && (!step_mode || step))
    begin
      if (count == COUNT_TOP)
      begin
        running <= 1'b0;
        ready   <= 1'b1;
      end
      else
        count <= count + 10'h001;
    end

endmodule

// ### hdl/csc_core.sv
// capacitive scan controller digital core: registers, scan and transfer sequencing
// How it works
// - a serial access is an 8-bit address then a 16-bit data word
// - address and data move most significant bit first in both directions
// - reply bits are driven on the rising serial clock edge
// - after power-up the core is held in reset for 8 cycles by default
// - writing the reset register loads the length and starts a software reset
// - calibration register holds upper ref, lower ref and stimulus frequency codes
// - upper ref resets to 1111, lower ref resets to 0001
// - frequency resets to 000111; a written 000000 becomes 000001
// - outside test mode the ramp counter steps once per clock from 0 to 1023, feeding the DAC
// - test mode register at 0x20; ramp start only changeable in test mode
// - transfer counter start is programmable and readable
// - two read-only addresses return the scan and transfer machine states
// - settling wait end value is 16 bits, default 640
// - wait counter clears, counts while enabled and reports ready at the end
// - stimulus gain code uses bits 3:0 and resets to 0011
// - gain code is output as binary and as one-out-of-fifteen
// - phase coefficient resets to 128, gain coefficient to 0, both readable
// - scan waits for trigger, resets, flags columns, settles, reads, waits readies
// - after a column the transfer starts; flag return ends the scan
// - the scan leaves a column only with both counter readies high
// - transfer drives syncs, coefficient strobe, counter and row shifts
// - a coefficient cycle loads phase coefficients and shifts rows but publishes no data
// - counters start from a pulse, run to 1023, shift, then report ready
// - global reset restores every programmed setting to its default
// - words per column run from the transfer start to 1023; rows from 800 up carry the phase coefficient
// - frame sync marks the first column, line sync each line, pixel clock = clock
// - column, row and row-counter resets are active low and asynchronous
`timescale 1ns/1ps
module csc_core
  import csc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sel_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        snap,
  input  wire logic        column_flag_in,
  input  wire logic [9:0]  row_data_in,
  output logic             core_reset_low,
  output logic             column_reset_low,
  output logic             row_reset_low,
  output logic             row_counter_reset_low,
  output logic             column_flag_out,
  output logic             column_shift_clock,
  output logic             row_coef_strobe,
  output logic             row_shift_clock,
  output logic [9:0]       phase_coef_out,
  output logic [9:0]       gain_coef_out,
  output logic [9:0]       dac_code,
  output logic [3:0]       upper_ref_code,
  output logic [3:0]       lower_ref_code,
  output logic [5:0]       stim_freq_code,
  output logic [3:0]       gain_code_binary,
  output logic [14:0]      gain_select_onehot,
  output logic             frame_sync_out,
  output logic             line_sync_out,
  output logic             pixel_clock,
  output logic [9:0]       data_out
);

  // one-hot state to its bit index, shared by both state readbacks
  function automatic logic [3:0] onehot_index(input logic [7:0] oh);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 8; i++)
      if (oh[i])
        idx = 4'(i);
    return idx;
  endfunction

  // gain code 1..15 selects one of fifteen taps, code 0 selects none
  function automatic logic [14:0] gain_decode(input logic [3:0] code);
    logic [14:0] sel;
    sel = 15'h0000;
    if (code != 4'h0)
      sel[4'(code - 4'h1)] = 1'b1;
    return sel;
  endfunction

  // programmed settings
  logic [3:0]       reset_len;
  csc_cal_t         cal;
  logic [9:0]       ramp_start;
  logic [9:0]       xfer_start;
  logic [15:0]      wait_end;
  logic [3:0]       stim_gain;
  logic [9:0]       phase_coef;
  logic [9:0]       gain_coef;
  logic             test_mode;
  logic             step_en;
  logic             step_pulse;

  // serial slave link
  csc_spi_req_t     wr_req;
  logic [7:0]       rd_addr;
  logic [15:0]      rd_data;

  // core reset sequencing
  logic [3:0]       hold_cnt;
  logic             core_hold;

  // pin synchronisers
  logic [2:0]       snap_s;
  logic [1:0]       cflag_s;
  logic [9:0]       din_s1;
  logic [9:0]       din_s2;

  // sequencing state
  csc_scan_state_t  scan_state;
  csc_scan_state_t  next_scan_state;
  csc_xfer_state_t  xfer_state;
  csc_xfer_state_t  next_xfer_state;
  logic [15:0]      wait_cnt;
  logic             wait_ready;
  logic             first_column;
  logic             frame_column;
  logic             publish;
  logic             normal_transfer_enable;
  logic             coefficient_cycle_enable;
  logic [9:0]       ramp_count;
  logic             ramp_running;
  logic             ramp_counter_ready;
  logic [9:0]       xfer_count;
  logic             xfer_running;
  logic             transfer_counter_ready;
  logic             col_rst_q;

  csc_spi_slave u_spi (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .spi_sclk    (spi_sclk),
    .spi_sel_n   (spi_sel_n),
    .spi_mosi    (spi_mosi),
    .rd_data     (rd_data),
    .rd_addr     (rd_addr),
    .wr_req      (wr_req),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe)
  );

  // every frame to a writable address stores its data (ramp start only in test mode) and returns the old value; defaults on reset
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      reset_len  <= RST_RESET_LEN;
      cal        <= '{RST_UPPER_REF, RST_LOWER_REF, 2'b00, RST_STIM_FREQ};
      ramp_start <= RST_RAMP_START;
      xfer_start <= RST_XFER_START;
      wait_end   <= RST_WAIT_END;
      stim_gain  <= RST_STIM_GAIN;
      phase_coef <= RST_PHASE_COEF;
      gain_coef  <= RST_GAIN_COEF;
      test_mode  <= 1'b0;
      step_en    <= 1'b0;
      step_pulse <= 1'b0;
    end
    else
    begin
      step_pulse <= 1'b0;
      if (wr_req.wr)
      begin
        unique case (wr_req.addr)
          ADDR_RESET_LEN:  reset_len <= wr_req.data[3:0];
          ADDR_CAL:
          begin
            cal <= {wr_req.data[15:8], 2'b00, wr_req.data[5:0]};
            if (wr_req.data[5:0] == STIM_FREQ_ILL)
              cal.stim_freq <= STIM_FREQ_MIN;
          end
          ADDR_RAMP_START:
            if (test_mode)
              ramp_start <= wr_req.data[9:0];
          ADDR_XFER_START: xfer_start <= wr_req.data[9:0];
          ADDR_WAIT_END:   wait_end   <= wr_req.data;
          ADDR_STIM_GAIN:  stim_gain  <= wr_req.data[3:0];
          ADDR_PHASE_COEF: phase_coef <= wr_req.data[9:0];
          ADDR_GAIN_COEF:  gain_coef  <= wr_req.data[9:0];
          ADDR_TEST_MODE:
          begin
            test_mode  <= wr_req.data[TM_ENABLE_BIT];
            step_en    <= wr_req.data[TM_STEP_EN_BIT];
            step_pulse <= wr_req.data[TM_STEP_BIT];
          end
          default: ;
        endcase
      end
    end

  // readback mux; unmapped addresses read zero
  always_comb
  begin
    rd_data = 16'h0000;
    unique case (rd_addr)
      ADDR_RESET_LEN:  rd_data = {12'h000, reset_len};
      ADDR_CAL:        rd_data = cal;
      ADDR_RAMP_START: rd_data = {6'h00, ramp_start};
      ADDR_XFER_START: rd_data = {6'h00, xfer_start};
      ADDR_SCAN_STATE: rd_data = {12'h000, onehot_index({2'b00, scan_state})};
      ADDR_XFER_STATE: rd_data = {12'h000, onehot_index({5'h00, xfer_state})};
      ADDR_WAIT_END:   rd_data = wait_end;
      ADDR_STIM_GAIN:  rd_data = {12'h000, stim_gain};
      ADDR_PHASE_COEF: rd_data = {6'h00, phase_coef};
      ADDR_GAIN_COEF:  rd_data = {6'h00, gain_coef};
      ADDR_TEST_MODE:  rd_data = {13'h0000, 1'b0, step_en, test_mode};
      default:         rd_data = 16'h0000;
    endcase
  end

  // core held low for reset_len plus one cycles after power-up or any reset write
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      hold_cnt  <= RST_RESET_LEN;
      core_hold <= 1'b1;
    end
    else if (wr_req.wr && wr_req.addr == ADDR_RESET_LEN)
    begin
      hold_cnt  <= wr_req.data[3:0];
      core_hold <= 1'b1;
    end
    else if (hold_cnt != 4'h0)
      hold_cnt <= hold_cnt - 4'h1;
    else
      core_hold <= 1'b0;

  assign core_reset_low = ~core_hold;

  // pins from other chips pass two flops first
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      snap_s  <= 3'b000;
      cflag_s <= 2'b00;
      din_s1  <= 10'h000;
      din_s2  <= 10'h000;
    end
    else
    begin
      snap_s  <= {snap_s[1:0], snap};
      cflag_s <= {cflag_s[0], column_flag_in};
      din_s1  <= row_data_in;
      din_s2  <= din_s1;
    end

  // settling wait: clear when idle, count while enabled, ready at end
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      wait_cnt <= 16'h0000;
    else if (scan_state != SCAN_SETTLE || core_hold)
      wait_cnt <= 16'h0000;
    else if (wait_cnt != wait_end)
      wait_cnt <= wait_cnt + 16'h0001;

  assign wait_ready = (scan_state == SCAN_SETTLE) && (wait_cnt == wait_end);

  // ramp counter feeds the dac; start is fixed at zero outside test mode
  csc_counter u_ramp (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .clear       (core_hold),
    .start       (scan_state == SCAN_READ),
    .start_value (test_mode ? ramp_start : RST_RAMP_START),
    .step_mode   (test_mode & step_en),
    .step        (step_pulse),
    .count       (ramp_count),
    .running     (ramp_running),
    .ready       (ramp_counter_ready)
  );

  // transfer counter paces the words of one column
  csc_counter u_xfer (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .clear       (core_hold),
    .start       (xfer_state == XFER_SYNC),
    .start_value (xfer_start),
    .step_mode   (test_mode & step_en),
    .step        (step_pulse),
    .count       (xfer_count),
    .running     (xfer_running),
    .ready       (transfer_counter_ready)
  );

  assign dac_code = ramp_count;

  // scan sequencer next state
  always_comb
  begin
    next_scan_state = scan_state;
    unique case (scan_state)
      SCAN_IDLE:
        if (snap_s[1] && !snap_s[2])
          next_scan_state = SCAN_CLEAR;
      SCAN_CLEAR:
        next_scan_state = SCAN_SETTLE;
      SCAN_SETTLE:
        if (wait_ready)
          next_scan_state = SCAN_READ;
      SCAN_READ:
        next_scan_state = SCAN_WAITRDY;
      SCAN_WAITRDY:
        // transfer machine idle too, so the next enable is never lost
        if (ramp_counter_ready && transfer_counter_ready && xfer_state == XFER_IDLE)
          next_scan_state = SCAN_NEXT;
      SCAN_NEXT:
        next_scan_state = cflag_s[1] ? SCAN_IDLE : SCAN_SETTLE;
      default:
        next_scan_state = SCAN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      scan_state <= SCAN_IDLE;
    else if (core_hold)
      scan_state <= SCAN_IDLE;
    else
      scan_state <= next_scan_state;

  // first column remembered until its transfer is launched
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      first_column <= 1'b0;
    else if (core_hold)
      first_column <= 1'b0;
    else if (scan_state == SCAN_CLEAR)
      first_column <= 1'b1;
    else if (scan_state == SCAN_NEXT)
      first_column <= 1'b0;

  assign coefficient_cycle_enable = (scan_state == SCAN_CLEAR);
  assign normal_transfer_enable   = (scan_state == SCAN_NEXT);
  assign column_shift_clock       = (scan_state == SCAN_READ);

  // scan-side control outputs, registered to keep them glitch free
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      col_rst_q       <= 1'b0;
      column_flag_out <= 1'b0;
    end
    else
    begin
      col_rst_q       <= ~core_hold && scan_state != SCAN_CLEAR;
      column_flag_out <= (scan_state == SCAN_CLEAR);
    end

  // external resets drop at once with the master reset
  assign column_reset_low      = rst_n & col_rst_q;
  assign row_reset_low         = rst_n & col_rst_q;
  assign row_counter_reset_low = rst_n & col_rst_q;

  // transfer sequencer next state
  always_comb
  begin
    next_xfer_state = xfer_state;
    unique case (xfer_state)
      XFER_IDLE:
        if (normal_transfer_enable || coefficient_cycle_enable)
          next_xfer_state = XFER_SYNC;
      XFER_SYNC:
        next_xfer_state = XFER_SHIFT;
      XFER_SHIFT:
        if (transfer_counter_ready)
          next_xfer_state = XFER_IDLE;
      default:
        next_xfer_state = XFER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      xfer_state <= XFER_IDLE;
    else if (core_hold)
      xfer_state <= XFER_IDLE;
    else
      xfer_state <= next_xfer_state;

  // coefficient-only cycles shift rows but publish nothing
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      publish      <= 1'b0;
      frame_column <= 1'b0;
    end
    else if (xfer_state == XFER_IDLE)
    begin
      publish      <= normal_transfer_enable;
      frame_column <= first_column;
    end

  assign row_coef_strobe = (xfer_state == XFER_SYNC);
  assign row_shift_clock = (xfer_state == XFER_SHIFT) && xfer_running;

  // word stream: absent rows carry the phase coefficient
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      data_out       <= 10'h000;
      line_sync_out  <= 1'b0;
      frame_sync_out <= 1'b0;
    end
    else
    begin
      data_out       <= 10'h000;
      line_sync_out  <= 1'b0;
      frame_sync_out <= 1'b0;
      if (row_shift_clock && publish)
      begin
        data_out       <= (xfer_count >= ROWS_PRESENT) ? phase_coef : din_s2;
        line_sync_out  <= (xfer_count == xfer_start);
        frame_sync_out <= frame_column;
      end
    end

  // coefficients shift into the row chips alongside the data
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      phase_coef_out <= RST_PHASE_COEF;
      gain_coef_out  <= RST_GAIN_COEF;
    end
    else
    begin
      phase_coef_out <= phase_coef;
      gain_coef_out  <= gain_coef;
    end

  // analogue settings straight from the registers
  assign upper_ref_code     = cal.upper_ref;
  assign lower_ref_code     = cal.lower_ref;
  assign stim_freq_code     = cal.stim_freq;
  assign gain_code_binary   = stim_gain;
  assign gain_select_onehot = gain_decode(stim_gain);
  assign pixel_clock        = ref_clk;

endmodule

// ### verif/csc_spi_master.sv
// serial register master standing in for the host
`timescale 1ns/1ps
module csc_spi_master
(
  output logic      spi_sclk,
  output logic      spi_sel_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // clock stands low and select high between frames
  initial
  begin
    spi_sclk = 1'b0;
    spi_sel_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one whole frame; the offset keeps our edges off the core clock edges
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {a, d};
    #7 spi_sel_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      #80 spi_mosi = f[i]; // msb first, set while clock is low
      #80 spi_sclk = 1'b1;
      #80 spi_sclk = 1'b0;
      if (i < 16) q[i] = spi_miso;
    end
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    #160 spi_sel_n = 1'b1;
    #160;
  endtask
endmodule

// ### verif/csc_core_assertions.sv
// port checker for the scan controller core
`timescale 1ns/1ps
module csc_core_assertions
  import csc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        spi_sel_n,
  input wire logic        spi_miso_oe,
  input wire logic        core_reset_low,
  input wire logic        column_flag_out,
  input wire logic        column_reset_low,
  input wire logic        row_shift_clock,
  input wire logic        line_sync_out,
  input wire logic [9:0]  data_out,
  input wire logic [3:0]  upper_ref_code,
  input wire logic [3:0]  lower_ref_code,
  input wire logic [5:0]  stim_freq_code,
  input wire logic [3:0]  gain_code_binary,
  input wire logic [14:0] gain_select_onehot
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_held;
    !core_reset_low [*7];
  endsequence
  a_core_hold: assert property ($rose(rst_n) |-> s_held ##[1:3] core_reset_low)
    else $error("core reset length wrong");
  a_refs_default: assert property ($rose(rst_n) |-> upper_ref_code == 4'hf && lower_ref_code == 4'h1 && stim_freq_code == 6'h07)
    else $error("reference defaults wrong");
  a_freq_legal: assert property (stim_freq_code != 6'h00)
    else $error("frequency code zero");
  a_gain_decode: assert property (gain_select_onehot == ((gain_code_binary == 4'h0) ? 15'h0000 : 15'h0001 << (gain_code_binary - 4'h1)))
    else $error("gain selection wrong");
  a_flag_pulse: assert property (column_flag_out |=> !column_flag_out)
    else $error("column flag too long");
  a_col_reset: assert property (column_flag_out |-> !column_reset_low)
    else $error("column reset not applied");
  a_line_pulse: assert property (line_sync_out |=> !line_sync_out)
    else $error("line sync too long");
  a_data_idle: assert property (!$past(row_shift_clock) |-> data_out == 10'h000)
    else $error("data without shift");
  a_reply_drive: assert property ($fell(spi_sel_n) |-> ##[1:3] spi_miso_oe)
    else $error("reply not driven");
endmodule
bind csc_core csc_core_assertions u_chk
(
  .ref_clk, .rst_n, .spi_sel_n, .spi_miso_oe, .core_reset_low, .column_flag_out,
  .column_reset_low, .row_shift_clock, .line_sync_out, .data_out, .upper_ref_code,
  .lower_ref_code,
  .stim_freq_code, .gain_code_binary, .gain_select_onehot
);

// ### verif/csc_core_tb.sv
// self-checking bench for the scan controller core
`timescale 1ns/1ps
module csc_core_tb
  import csc_pkg::*;
;
  logic        ref_clk = 1'b0, rst_n = 1'b0, snap = 1'b0, column_flag_in = 1'b0;
  logic [9:0]  row_data_in = 10'h155, dmax = 10'h000;
  wire         spi_sclk, spi_sel_n, spi_mosi, spi_miso, row_shift_clock;
  wire         frame_sync_out, line_sync_out;
  wire  [9:0]  data_out, dac_code, phase_coef_out, gain_coef_out;
  wire  [3:0]  upper_ref_code, lower_ref_code, gain_code_binary;
  wire  [5:0]  stim_freq_code;
  logic [15:0] m [0:255], q;
  logic [31:0] seed = 32'h7f46;
  logic [7:0]  al [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0a, 8'h10, 8'h11,
                           8'h1f, 8'h20, 8'h06, 8'h30};
  int          num_errors = 0, n_tests = 0, nf = 0, nl = 0, np = 0, nd = 0;
  csc_core dut (.ref_clk, .rst_n, .spi_sclk, .spi_sel_n, .spi_mosi, .spi_miso,
    .spi_miso_oe(), .snap, .column_flag_in, .row_data_in, .core_reset_low(),
    .column_reset_low(), .row_reset_low(), .row_counter_reset_low(), .column_flag_out(),
    .column_shift_clock(), .row_coef_strobe(), .row_shift_clock, .phase_coef_out,
    .gain_coef_out, .dac_code, .upper_ref_code, .lower_ref_code, .stim_freq_code,
    .gain_code_binary, .gain_select_onehot(), .frame_sync_out, .line_sync_out,
    .pixel_clock(), .data_out);
  csc_spi_master u_m (.spi_sclk, .spi_sel_n, .spi_mosi, .spi_miso);
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  // stream tallies; words of the phase value mark the absent rows
  always @(posedge ref_clk)
  begin
    nf <= nf + frame_sync_out;
    nl <= nl + line_sync_out;
    np <= np + (data_out === m[16][9:0]);
    nd <= nd + (data_out === row_data_in);
    if (dac_code > dmax) dmax <= dac_code;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // writable bits of each address; unmapped and state addresses keep none
  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      8'h01: msk = 16'hff3f;
      8'h02, 8'h03, 8'h10, 8'h11: msk = 16'h03ff;
      8'h09: msk = 16'hffff;
      8'h0a, 8'h1f: msk = 16'h000f;
      8'h20: msk = 16'h0003;
      default: msk = 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // every frame returns the old content and writes the new one, except ramp start outside test mode
  task automatic acc(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] e;
    e = m[a];
    u_m.xfer(a, d, q);
    chk(q, e);
    if (a != 8'h02 || m[32][0]) m[a] = d & msk(a);
    if (a == 8'h01 && d[5:0] == 6'h00) m[1][0] = 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({upper_ref_code, lower_ref_code, 2'b00, stim_freq_code}, m[1]);
    chk({gain_code_binary, 2'b00, phase_coef_out}, {m[10][3:0], 2'b00, m[16][9:0]});
    chk({6'h00, gain_coef_out}, m[17]);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #1000000 num_errors++;
    close_out();
  end
  initial
  begin
    logic [7:0] a;
    m = '{default: 16'h0000};
    m[1] = 16'hf107;
    m[9] = 16'h0280;
    m[10] = 16'h0003;
    m[16] = 16'h0080;
    m[31] = 16'h0007;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (al[i]) acc(al[i], m[al[i]]);
    repeat (24)
    begin
      a = al[xs() % 13];
      acc(a, xs());
    end
    acc(8'h01, 16'h5a00);
    $display("end of register test");
    acc(8'h20, 16'h0000);
    acc(8'h02, 16'h0155);
    acc(8'h20, 16'h0001);
    acc(8'h02, 16'h0123);
    acc(8'h02, 16'h0000);
    acc(8'h20, 16'h0000);
    $display("end of test mode test");
    acc(8'h09, 16'h0004);
    acc(8'h03, 16'h031a);
    acc(8'h10, 16'h02aa);
    // cleared off the edge so no tally update overwrites it
    @(negedge ref_clk);
    {nf, nl, np, nd} = '0;
    @(posedge ref_clk);
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
    for (int i = 0; i < 9000 && nl == 0; i++) @(posedge ref_clk);
    column_flag_in <= 1'b1; // second column ends the scan
    for (int i = 0; i < 9000 && nl < 2; i++) @(posedge ref_clk);
    repeat (400) @(posedge ref_clk);
    chk(16'(nf), 16'(1024 - 10'h31a));
    chk(16'(nl), 16'h0002);
    chk(16'(np), 16'(2 * (1024 - 800)));
    chk(16'(nd), 16'(2 * (800 - 10'h31a)));
    chk({6'h00, dmax}, 16'h03ff);
    acc(8'h04, 16'h0000);
    acc(8'h05, 16'h0000);
    $display("end of scan test");
    close_out();
  end
endmodule
